/* File: rtl/fp_pkg.sv */
package fp_pkg;

    // System clock rate in hertz.
    localparam int CLK_HZ = 25_000_000;

    // Times as printed, in their own units.
    localparam int HOLD_DHCP_S   = 5;
    localparam int HOLD_FACT_S   = 10;
    localparam int TAP_WIN_S     = 3;
    localparam int LOCK_WIN_MS   = 100;
    localparam int DEBOUNCE_MS   = 10;
    localparam int BLINK_FAST_MS = 125;
    localparam int DARK_MS       = 1000;

    // Cycle counts derived from the times; every figure divides exactly.
    localparam int HOLD_DHCP_CYC = HOLD_DHCP_S * CLK_HZ;
    localparam int HOLD_FACT_CYC = HOLD_FACT_S * CLK_HZ;
    localparam int TAP_WIN_CYC   = TAP_WIN_S * CLK_HZ;
    localparam int LOCK_WIN_CYC  = (CLK_HZ / 1000) * LOCK_WIN_MS;
    localparam int DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int BLINK_CYC     = (CLK_HZ / 1000) * BLINK_FAST_MS;
    localparam int DARK_CYC      = (CLK_HZ / 1000) * DARK_MS;

    // Counter width; holds the ten second hold count.
    localparam int CNT_W = 28;

    // Blink counts, as half phases of the fast blink, and the tap count at which the last tap completes a sequence.
    localparam logic [3:0] FLASH_LOCK  = 4'h8;
    localparam logic [3:0] FLASH_QUICK = 4'h6;
    localparam logic [3:0] FLASH_SEL   = 4'h2;
    localparam logic [1:0] TAPS_LAST   = 2'h2;

    // Port counts and button bit positions.
    localparam int NIN   = 4;
    localparam int NOUT  = 3;
    localparam int NGPIO = 6;
    localparam int NBTN  = 8;
    localparam int B_OUT0 = 4;
    localparam int B_AUD  = 7;

    // Register byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_GDIR  = 8'h04;
    localparam logic [7:0] A_GOUT  = 8'h08;
    localparam logic [7:0] A_ROUTE = 8'h0c;
    localparam logic [7:0] A_STAT  = 8'h10;

    // Status register field positions.
    localparam int ST_OCC  = 8;
    localparam int ST_LOCK = 9;
    localparam int ST_SEQ  = 10;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Hold and tap sequence states.
    typedef enum logic [1:0] {S_IDLE, S_HOLD, S_TAPS, S_DONE} seq_t;

    // Software settings, in control register bit order from bit 3 down.
    typedef struct packed {
        logic dhcp;
        logic occ_low;
        logic dark;
        logic three_out;
    } ctrl_t;

    // Video status from the switching core.
    typedef struct packed {
        logic [NIN-1:0]  in_valid;
        logic [NOUT-1:0] out_present;
        logic [NOUT-1:0] out_muted;
    } video_stat_t;

    // Ethernet status from the network port.
    typedef struct packed {
        logic link;
        logic activity;
        logic speed_100;
    } eth_stat_t;

    // Front panel lamps.
    typedef struct packed {
        logic [NIN-1:0]  in_led;
        logic [NOUT-1:0] out_led;
        logic            eth_amber;
        logic            eth_green;
    } leds_t;

    // Whole state of the panel controller.
    typedef struct packed {
        logic [NBTN-1:0]  s1, s2, db, dbp;
        logic [CNT_W-1:0] deb_cnt, fcnt, scnt, w1, w4;
        logic             fph, sph, fac, lock, flash_all, reboot;
        seq_t             seq;
        logic [1:0]       taps;
        logic [3:0]       flash_n, flash_mask;
        ctrl_t            ctrl;
        logic [NGPIO-1:0] gdir, gout, gs1, gs2;
        logic             os1, os2;
        logic [5:0]       vroute;
        logic [1:0]       aroute;
        leds_t            leds;
        logic             awrdy, wrdy, aw_have, w_have, bvalid;
        logic             arrdy, rvalid;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]      wdata, rdata;
        logic             wlane0;
        logic [1:0]       bresp, rresp;
    } state_t;

endpackage : fp_pkg

/* File: rtl/front_panel_ctrl.sv */
`timescale 1ns/1ps
module front_panel_ctrl #(
    parameter int HOLD_DHCP_CYC = fp_pkg::HOLD_DHCP_CYC,
    parameter int HOLD_FACT_CYC = fp_pkg::HOLD_FACT_CYC,
    parameter int TAP_WIN_CYC   = fp_pkg::TAP_WIN_CYC,
    parameter int LOCK_WIN_CYC  = fp_pkg::LOCK_WIN_CYC,
    parameter int DEBOUNCE_CYC  = fp_pkg::DEBOUNCE_CYC,
    parameter int BLINK_CYC     = fp_pkg::BLINK_CYC,
    parameter int DARK_CYC      = fp_pkg::DARK_CYC
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [fp_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                       wvalid,
    output logic                            wready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    output logic                            bvalid,
    input  wire logic                       bready,
    output logic [1:0]                      bresp,
    input  wire logic                       arvalid,
    output logic                            arready,
    input  wire logic [fp_pkg::ADDR_W-1:0]  araddr,
    output logic                            rvalid,
    input  wire logic                       rready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    input  wire logic [fp_pkg::NIN-1:0]     input_select_buttons,
    input  wire logic [fp_pkg::NOUT-1:0]    output_select_buttons,
    input  wire logic                       audio_source_button,
    input  wire fp_pkg::video_stat_t        video_stat,
    input  wire fp_pkg::eth_stat_t          eth_stat,
    input  wire logic                       occupancy_sensor_input,
    input  wire logic [fp_pkg::NGPIO-1:0]   gpio_in,
    output logic [fp_pkg::NGPIO-1:0]        gpio_out,
    output logic [fp_pkg::NGPIO-1:0]        gpio_oe,
    output fp_pkg::leds_t                   leds,
    output logic [5:0]                      video_route,
    output logic [1:0]                      audio_route,
    output logic                            dhcp_enable,
    output logic                            factory_reboot
);

    ////////////////////////////////////////////////////////////////////////

    // Registered state and its next value.
    fp_pkg::state_t q_q, q_d;

    // Press edges and the two buttons that form the lock chord.
    logic [fp_pkg::NBTN-1:0] rise;
    logic b1, b4, r1, r4, combo, act, wr_fire, seq_blink, ph;

    // Saturating count up; a long hold never wraps into a short one.
    function automatic logic [fp_pkg::CNT_W-1:0] sat_inc(
        input logic [fp_pkg::CNT_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction : sat_inc

    // Count down to zero and stay there.
    function automatic logic [fp_pkg::CNT_W-1:0] dec0(
        input logic [fp_pkg::CNT_W-1:0] v);
        return (v == '0) ? v : v - 1'b1;
    endfunction : dec0

    // Next input in fixed order, wrapping from the last to the first.
    function automatic logic [1:0] next_in(input logic [1:0] v);
        return v + 2'h1;
    endfunction : next_in

    ////////////////////////////////////////////////////////////////////////

    // The chord and the hold button depend on the variant.
    assign rise    = q_q.db & ~q_q.dbp;
    assign b1      = q_q.ctrl.three_out ? q_q.db[fp_pkg::B_OUT0] : q_q.db[0];
    assign b4      = q_q.ctrl.three_out ? q_q.db[fp_pkg::B_AUD]
                                        : q_q.db[fp_pkg::NIN-1];
    assign r1      = q_q.ctrl.three_out ? rise[fp_pkg::B_OUT0] : rise[0];
    assign r4      = q_q.ctrl.three_out ? rise[fp_pkg::B_AUD]
                                        : rise[fp_pkg::NIN-1];
    assign combo   = b1 & b4 & ((r4 & (r1 | (q_q.w1 != '0)))
                                | (r1 & (q_q.w4 != '0)));
    // Normal functions only when unlocked and no sequence is running.
    assign act     = ~q_q.lock & ~combo & (q_q.seq == fp_pkg::S_IDLE);
    assign wr_fire = q_q.aw_have & q_q.w_have & ~q_q.bvalid;
    assign seq_blink = (q_q.seq == fp_pkg::S_TAPS)
        | ((q_q.seq == fp_pkg::S_HOLD)
           && (q_q.scnt >= fp_pkg::CNT_W'(HOLD_DHCP_CYC)));
    assign ph = ((q_q.seq == fp_pkg::S_TAPS) ? q_q.fac
        : (q_q.scnt >= fp_pkg::CNT_W'(HOLD_FACT_CYC))) ? q_q.fph : q_q.sph;

    ////////////////////////////////////////////////////////////////////////

    // Next-state logic for the whole block.
    always_comb begin
        q_d = q_q;
        q_d.s1  = {audio_source_button, output_select_buttons,
                   input_select_buttons};
        q_d.s2  = q_q.s1;
        q_d.gs1 = gpio_in;
        q_d.gs2 = q_q.gs1;
        q_d.os1 = occupancy_sensor_input;
        q_d.os2 = q_q.os1;
        q_d.dbp = q_q.db;
        q_d.reboot = 1'b0;
        if (q_q.deb_cnt == fp_pkg::CNT_W'(DEBOUNCE_CYC - 1)) begin
            q_d.deb_cnt = '0;
            q_d.db      = q_q.s2;
        end else begin
            q_d.deb_cnt = q_q.deb_cnt + 1'b1;
        end
        // Fast blink ticks every half phase; the slow one is half its rate.
        if (q_q.fcnt == fp_pkg::CNT_W'(BLINK_CYC - 1)) begin
            q_d.fcnt = '0;
            q_d.fph  = ~q_q.fph;
            q_d.sph  = q_q.sph ^ q_q.fph;
            if (q_q.flash_n != 4'h0) begin
                q_d.flash_n = q_q.flash_n - 4'h1;
            end
        end else begin
            q_d.fcnt = q_q.fcnt + 1'b1;
        end

        // Write channel: address and data are taken in either order.
        if (awvalid && q_q.awrdy) begin
            q_d.aw_have = 1'b1;
            q_d.awaddr  = awaddr;
        end
        if (wvalid && q_q.wrdy) begin
            q_d.w_have = 1'b1;
            q_d.wdata  = wdata;
            q_d.wlane0 = wstrb[0];
        end
        if (q_q.bvalid && bready) begin
            q_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            q_d.aw_have = 1'b0;
            q_d.w_have  = 1'b0;
            q_d.bvalid  = 1'b1;
            q_d.bresp   = fp_pkg::RESP_OKAY;
            // Every field sits in byte lane 0; other lanes are ignored.
            unique case (q_q.awaddr)
                fp_pkg::A_CTRL: begin
                    if (q_q.wlane0) q_d.ctrl = q_q.wdata[3:0];
                end
                fp_pkg::A_GDIR: begin
                    if (q_q.wlane0) q_d.gdir = q_q.wdata[5:0];
                end
                fp_pkg::A_GOUT: begin
                    if (q_q.wlane0) q_d.gout = q_q.wdata[5:0];
                end
                fp_pkg::A_ROUTE: begin
                    if (q_q.wlane0) begin
                        q_d.vroute = q_q.wdata[5:0];
                        q_d.aroute = q_q.wdata[7:6];
                    end
                end
                // Status is read only; a write is accepted and dropped.
                fp_pkg::A_STAT: begin
                end
                default: q_d.bresp = fp_pkg::RESP_SLVERR;
            endcase
        end
        q_d.awrdy = ~q_d.aw_have & ~q_d.bvalid;
        q_d.wrdy  = ~q_d.w_have & ~q_d.bvalid;

        // Read channel: one cycle from address to data.
        if (q_q.rvalid && rready) begin
            q_d.rvalid = 1'b0;
        end
        if (arvalid && q_q.arrdy) begin
            q_d.rvalid = 1'b1;
            q_d.rdata  = '0;
            q_d.rresp  = fp_pkg::RESP_OKAY;
            unique case (araddr)
                fp_pkg::A_CTRL:  q_d.rdata[3:0] = q_q.ctrl;
                fp_pkg::A_GDIR:  q_d.rdata[5:0] = q_q.gdir;
                fp_pkg::A_GOUT:  q_d.rdata[5:0] = q_q.gout;
                fp_pkg::A_ROUTE: q_d.rdata[7:0] = {q_q.aroute, q_q.vroute};
                fp_pkg::A_STAT: begin
                    q_d.rdata[5:0] = q_q.gs2;
                    q_d.rdata[fp_pkg::ST_OCC]  = q_q.os2 ^ q_q.ctrl.occ_low;
                    q_d.rdata[fp_pkg::ST_LOCK] = q_q.lock;
                    q_d.rdata[fp_pkg::ST_SEQ+:2] = q_q.seq;
                end
                default: q_d.rresp = fp_pkg::RESP_SLVERR;
            endcase
        end
        q_d.arrdy = ~q_d.rvalid;

        // Lock chord windows restart on each press of the two buttons.
        q_d.w1 = r1 ? fp_pkg::CNT_W'(LOCK_WIN_CYC) : dec0(q_q.w1);
        q_d.w4 = r4 ? fp_pkg::CNT_W'(LOCK_WIN_CYC) : dec0(q_q.w4);
        if (combo) begin
            q_d.lock      = ~q_q.lock;
            q_d.flash_all = 1'b1;
            q_d.flash_n   = fp_pkg::FLASH_LOCK;
        end else if (q_q.lock && (rise != '0)) begin
            q_d.flash_all = 1'b1;
            q_d.flash_n   = fp_pkg::FLASH_QUICK;
        end else if (act && !q_q.ctrl.three_out) begin
            for (int i = 0; i < fp_pkg::NIN; i++) begin
                if (rise[i]) begin
                    q_d.vroute[1:0] = 2'(i);
                    q_d.flash_all   = 1'b0;
                    q_d.flash_mask  = 4'h1 << i;
                    q_d.flash_n     = fp_pkg::FLASH_SEL;
                end
            end
        end else if (act) begin
            for (int j = 0; j < fp_pkg::NOUT; j++) begin
                if (rise[fp_pkg::B_OUT0 + j]) begin
                    q_d.vroute[2*j+:2] = next_in(q_d.vroute[2*j+:2]);
                    q_d.flash_all      = 1'b0;
                    q_d.flash_mask     = 4'h1 << q_d.vroute[2*j+:2];
                    q_d.flash_n        = fp_pkg::FLASH_SEL;
                end
            end
            if (rise[fp_pkg::B_AUD]) begin
                q_d.aroute     = next_in(q_d.aroute);
                q_d.flash_all  = 1'b0;
                q_d.flash_mask = 4'h1 << q_d.aroute;
                q_d.flash_n    = fp_pkg::FLASH_SEL;
            end
        end

        // Hold and tap sequence on the fourth input button, or on the audio button in the three-output variant.
        unique case (q_q.seq)
            fp_pkg::S_IDLE: begin
                if (r4 && !q_q.lock && !combo) begin
                    q_d.seq  = fp_pkg::S_HOLD;
                    q_d.scnt = '0;
                end
            end
            fp_pkg::S_HOLD: begin
                q_d.taps = '0;
                if (b4) begin
                    q_d.scnt = sat_inc(q_q.scnt);
                end else if (q_q.scnt >= fp_pkg::CNT_W'(HOLD_DHCP_CYC)) begin
                    q_d.seq  = fp_pkg::S_TAPS;
                    q_d.fac  = q_q.scnt >= fp_pkg::CNT_W'(HOLD_FACT_CYC);
                    q_d.scnt = '0;
                end else begin
                    q_d.seq = fp_pkg::S_IDLE;
                end
            end
            fp_pkg::S_TAPS: begin
                q_d.scnt = sat_inc(q_q.scnt);
                if (q_q.scnt >= fp_pkg::CNT_W'(TAP_WIN_CYC)) begin
                    q_d.seq = fp_pkg::S_IDLE;
                end else if (r4 && q_q.taps == fp_pkg::TAPS_LAST) begin
                    q_d.seq  = fp_pkg::S_DONE;
                    q_d.scnt = '0;
                    if (q_q.fac) begin
                        q_d.ctrl   = '0;
                        q_d.ctrl.three_out = q_q.ctrl.three_out;
                        q_d.gdir   = '0;
                        q_d.gout   = '0;
                        q_d.vroute = '0;
                        q_d.aroute = '0;
                        q_d.lock   = 1'b0;
                        q_d.reboot = 1'b1;
                    end else begin
                        q_d.ctrl.dhcp = 1'b1;
                    end
                end else if (r4) begin
                    q_d.taps = q_q.taps + 2'h1;
                end
            end
            fp_pkg::S_DONE: begin
                q_d.scnt = sat_inc(q_q.scnt);
                if (q_q.scnt >= fp_pkg::CNT_W'(DARK_CYC)) begin
                    q_d.seq = fp_pkg::S_IDLE;
                end
            end
        endcase

        q_d.leds.in_led = video_stat.in_valid;
        for (int i = 0; i < fp_pkg::NIN; i++) begin
            if (q_q.flash_mask[i] && !q_q.flash_all && q_q.flash_n != 4'h0)
                q_d.leds.in_led[i] = q_q.flash_n[0];
        end
        q_d.leds.out_led = video_stat.out_present & ~video_stat.out_muted;
        q_d.leds.eth_amber = eth_stat.link & (~eth_stat.activity | q_q.sph);
        q_d.leds.eth_green = eth_stat.link & eth_stat.speed_100;
        if (seq_blink) begin
            q_d.leds = {$bits(fp_pkg::leds_t){ph}};
        end else if (q_q.flash_all && q_q.flash_n != 4'h0) begin
            q_d.leds = {$bits(fp_pkg::leds_t){q_q.flash_n[0]}};
        end
        // dark mode, and dark after a sequence
        if (q_q.ctrl.dark || q_q.seq == fp_pkg::S_DONE) begin
            q_d.leds = '0;
        end
    end

    // Synchronous reset to the all-zero state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // Outputs come straight from state bits.
    assign awready        = q_q.awrdy;
    assign wready         = q_q.wrdy;
    assign bvalid         = q_q.bvalid;
    assign bresp          = q_q.bresp;
    assign arready        = q_q.arrdy;
    assign rvalid         = q_q.rvalid;
    assign rdata          = q_q.rdata;
    assign rresp          = q_q.rresp;
    assign gpio_out       = q_q.gout;
    assign gpio_oe        = q_q.gdir;
    assign leds           = q_q.leds;
    assign video_route    = q_q.vroute;
    assign audio_route    = q_q.aroute;
    assign dhcp_enable    = q_q.ctrl.dhcp;
    assign factory_reboot = q_q.reboot;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_in_sel;
        act && !q_q.ctrl.three_out && rise[0] |=> q_q.vroute[1:0] == 2'h0;
    endproperty
    a_in_sel: assert property (p_in_sel) else $error("input select");

    property p_out_step;
        act && q_q.ctrl.three_out && rise[fp_pkg::B_OUT0] && !wr_fire
        |=> q_q.vroute[1:0] == 2'($past(q_q.vroute[1:0]) + 2'h1);
    endproperty
    a_out_step: assert property (p_out_step) else $error("out step");

    property p_aud_step;
        act && q_q.ctrl.three_out && rise[fp_pkg::B_AUD] && !wr_fire
        |=> q_q.aroute == 2'($past(q_q.aroute) + 2'h1);
    endproperty
    a_aud_step: assert property (p_aud_step) else $error("audio step");

    property p_lock;
        combo |=> q_q.lock != $past(q_q.lock) && q_q.flash_all
                  && q_q.flash_n == fp_pkg::FLASH_LOCK;
    endproperty
    a_lock: assert property (p_lock) else $error("lock toggle");

    property p_locked;
        q_q.lock && rise != '0 && !combo
        |=> q_q.flash_n == fp_pkg::FLASH_QUICK && $stable(q_q.vroute);
    endproperty
    a_locked: assert property (p_locked) else $error("locked press");

    property p_dark;
        q_q.ctrl.dark |=> q_q.leds == '0;
    endproperty
    a_dark: assert property (p_dark) else $error("dark mode");

    property p_dhcp;
        q_q.seq == fp_pkg::S_TAPS && !q_q.fac && r4
        && q_q.taps == fp_pkg::TAPS_LAST
        && q_q.scnt < fp_pkg::CNT_W'(TAP_WIN_CYC)
        |=> dhcp_enable && q_q.seq == fp_pkg::S_DONE ##1 q_q.leds == '0;
    endproperty
    a_dhcp: assert property (p_dhcp) else $error("dhcp sequence");

    property p_abandon;
        q_q.seq == fp_pkg::S_TAPS && q_q.scnt >= fp_pkg::CNT_W'(TAP_WIN_CYC)
        |=> q_q.seq == fp_pkg::S_IDLE && $stable(q_q.ctrl) && !factory_reboot;
    endproperty
    a_abandon: assert property (p_abandon) else $error("abandon");

    property p_out_led;
        !q_q.ctrl.dark && q_q.seq == fp_pkg::S_IDLE
        && !(q_q.flash_all && q_q.flash_n != 4'h0)
        |=> q_q.leds.out_led
            == $past(video_stat.out_present & ~video_stat.out_muted);
    endproperty
    a_out_led: assert property (p_out_led) else $error("output led");

    c_lock: cover property (combo ##1 q_q.lock);
    c_dhcp: cover property (q_q.seq == fp_pkg::S_DONE && dhcp_enable);
    c_fact: cover property (factory_reboot);

endmodule : front_panel_ctrl

/* File: testbench/panel_operator.sv */
`timescale 1ns/1ps
// Behavioural panel operator; buttons rest released between presses.
module panel_operator (
    input  wire logic  aclk,
    output logic [7:0] btn
);
    initial btn = 8'h00;
    task automatic press(input logic [7:0] m, input int n, input int g);
        btn <= m;
        repeat (n) @(posedge aclk);
        btn <= 8'h00;
        repeat (g) @(posedge aclk);
    endtask : press
    task automatic taps(input int g);
        repeat (3) press(8'h80, 20, g);
    endtask : taps
endmodule : panel_operator

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, occ = 1, awready, wready, bvalid;
    logic arready, rvalid, dhcp_enable, factory_reboot;
    logic [7:0] awaddr = 0, araddr = 0, btn;
    logic [31:0] wdata = 0, rdata;
    logic [8:0] exp_leds;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, audio_route;
    logic [5:0] gpio_in = 0, gpio_out, gpio_oe, video_route;
    fp_pkg::video_stat_t video_stat = 0;
    fp_pkg::eth_stat_t eth_stat = 0;
    fp_pkg::leds_t leds;
    logic [33:0] q[$];
    int fails = 0, cmp_count = 0, seen = 0, tn = 0;
    always #20 aclk = ~aclk;
    panel_operator i_op (.aclk, .btn);
    // Short counts keep hold and tap sequences within a brief run.
    front_panel_ctrl #(.HOLD_DHCP_CYC(200), .HOLD_FACT_CYC(400),
        .TAP_WIN_CYC(150), .DEBOUNCE_CYC(4),
        .BLINK_CYC(8), .DARK_CYC(30)) i_dut (.aclk, .aresetn, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .input_select_buttons(btn[3:0]),
        .output_select_buttons(btn[6:4]), .audio_source_button(btn[7]),
        .video_stat, .eth_stat, .occupancy_sensor_input(occ), .gpio_in,
        .gpio_out, .gpio_oe, .leds, .video_route, .audio_route,
        .dhcp_enable, .factory_reboot);
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic lim(input int k);
        if (k >= 99) begin
            fails++;
            summarize;
        end else begin
            tn++;
            $display("access %0d done", tn);
        end
    endtask : lim
    function automatic logic [33:0] ok(input logic [31:0] v);
        return {fp_pkg::RESP_OKAY, v};
    endfunction : ok
    // Both channels offered together; each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        q.push_back((a > fp_pkg::A_STAT) ? 34'(fp_pkg::RESP_SLVERR)
                                          : 34'(fp_pkg::RESP_OKAY));
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 99 && (awvalid || wvalid || !bvalid); k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end
        bready <= 0;
        lim(k);
    endtask : wr
    // The expected word is queued before the request goes out.
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        q.push_back(e);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 99 && (arvalid || !rvalid); k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end
        rready <= 0;
        lim(k);
    endtask : rd
    // Watcher pairs each read or write answer with the oldest queued note.
    always @(posedge aclk) begin
        if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
        if (bvalid && bready) chk(34'(bresp), q.pop_front());
        if (factory_reboot) seen++;
    end
    initial begin
        void'($urandom(82541));
        repeat (10) @(posedge aclk);
        aresetn    <= 1'b1;
        video_stat <= 10'($urandom);
        eth_stat   <= 3'($urandom);
        gpio_in    <= 6'($urandom);
        rd(fp_pkg::A_ROUTE, ok(0));
        rd(8'h20, {fp_pkg::RESP_SLVERR, 32'h0});
        wr(8'h20, 32'h1);
        i_op.press(8'h04, 20, 20);
        rd(fp_pkg::A_ROUTE, ok(2));
        i_op.press(8'h01, 20, 20);
        rd(fp_pkg::A_ROUTE, ok(0));
        wr(fp_pkg::A_CTRL, 1);
        repeat (2) i_op.press(8'h20, 20, 20);
        repeat (4) i_op.press(8'h10, 20, 20);
        rd(fp_pkg::A_ROUTE, ok(32'h08));
        i_op.press(8'h80, 20, 20);
        rd(fp_pkg::A_ROUTE, ok(32'h48));
        chk(34'(audio_route), 34'h1);
        rd(fp_pkg::A_CTRL, ok(1));
        i_op.press(8'h80, 250, 20);
        i_op.taps(20);
        chk(34'(dhcp_enable), 34'h1);
        repeat (40) @(posedge aclk);
        wr(fp_pkg::A_CTRL, 32'hb);
        repeat (4) @(posedge aclk);
        chk(34'(leds), 34'h0);
        wr(fp_pkg::A_CTRL, 9);
        video_stat <= 10'($urandom);
        eth_stat   <= 3'($urandom) & 3'h5;
        repeat (3) @(posedge aclk);
        exp_leds = {video_stat.in_valid,
                    video_stat.out_present & ~video_stat.out_muted,
                    eth_stat.link, eth_stat.link & eth_stat.speed_100};
        chk(34'(leds), 34'(exp_leds));
        i_op.press(8'h90, 20, 20);
        rd(fp_pkg::A_STAT, ok(32'h300 | 32'(gpio_in)));
        i_op.press(8'h20, 20, 60);
        chk(34'(video_route[3:2]), 34'h2);
        i_op.press(8'h90, 20, 80);
        wr(fp_pkg::A_CTRL, 32'hd);
        occ <= 0;
        repeat (2) @(posedge aclk);
        rd(fp_pkg::A_STAT, ok(32'h100 | 32'(gpio_in)));
        occ <= 1;
        repeat (2) @(posedge aclk);
        rd(fp_pkg::A_STAT, ok(32'(gpio_in)));
        wstrb <= 4'he;
        wr(fp_pkg::A_GDIR, 32'h3f);
        wstrb <= 4'hf;
        rd(fp_pkg::A_GDIR, ok(0));
        wr(fp_pkg::A_GDIR, 32'h15);
        wr(fp_pkg::A_GOUT, 32'h3f);
        chk(34'(gpio_out & gpio_oe), 34'h15);
        i_op.press(8'h80, 450, 20);
        i_op.taps(20);
        repeat (40) @(posedge aclk);
        chk(34'(seen), 34'h1);
        rd(fp_pkg::A_GDIR, ok(0));
        i_op.press(8'h80, 250, 20);
        i_op.taps(100);
        chk(34'(dhcp_enable), 34'h0);
        summarize;
    end
endmodule : tb
